/* File: rtl/bidir_shift_register8.sv */
// Eight-bit register with parallel load, left and right shift, and hold.
`include "bidir_shift_map.svh"
// ==========================================================================
module bidir_shift_register8 #(
  parameter int unsigned DEPTH = `BSR_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic clk_in_i,
  input wire logic [1:0] sel_i,
  input wire logic ser_lo_i,
  input wire logic ser_hi_i,
  input wire logic [`BSR_WIDTH-1:0] par_i,
  input wire logic snap_ready_i,
  output logic [`BSR_WIDTH-1:0] q_o,
  output logic defined_o,
  output logic edge_ready_o,
  output logic overrun_o,
  output logic snap_valid_o,
  output bsr_pkg::snap_t snap_data_o
);
  localparam int unsigned W = `BSR_WIDTH;

  // ==========================================================================
  // State and FIFO wiring
  bsr_pkg::top_state_t st_r;
  bsr_pkg::top_state_t st_nxt;
  bsr_pkg::mode_t mode;
  bsr_pkg::snap_t push_data;
  bsr_pkg::snap_t pop_data;
  logic fire;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;

  // The pin clock is sampled by mclk_i, so it must stay below half of 40 MHz.
  assign fire = clk_in_i && !st_r.clk_prev;

  always_comb
  begin
    unique case (sel_i)
      `BSR_SEL_LOAD: mode = bsr_pkg::MODE_LOAD;
      `BSR_SEL_LEFT: mode = bsr_pkg::MODE_LEFT;
      `BSR_SEL_RIGHT: mode = bsr_pkg::MODE_RIGHT;
      `BSR_SEL_HOLD: mode = bsr_pkg::MODE_HOLD;
    endcase
  end

  assign pop_ready = !st_r.out_valid || snap_ready_i;

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.clk_prev = clk_in_i;
    st_nxt.overrun = 1'b0;
    st_nxt.ready = push_ready;
    if (fire)
    begin
      unique case (mode)
        bsr_pkg::MODE_LOAD:
        begin
          st_nxt.q = par_i;
          st_nxt.mask = `BSR_MASK_ALL;
        end
        bsr_pkg::MODE_LEFT:
        begin
          st_nxt.q = {st_r.q[W-2:0], ser_lo_i};
          st_nxt.mask = {st_r.mask[W-2:0], 1'b1};
        end
        bsr_pkg::MODE_RIGHT:
        begin
          st_nxt.q = {ser_hi_i, st_r.q[W-1:1]};
          st_nxt.mask = {1'b1, st_r.mask[W-1:1]};
        end
        bsr_pkg::MODE_HOLD:
        begin
          st_nxt.q = st_r.q;
        end
      endcase
    end
    st_nxt.defined = &st_nxt.mask;
    // The register never stalls; a full FIFO only loses the snapshot.
    if (push_valid && !push_ready)
    begin
      st_nxt.overrun = 1'b1;
    end
    if (st_r.out_valid && snap_ready_i)
    begin
      st_nxt.out_valid = 1'b0;
    end
    if (pop_valid && pop_ready)
    begin
      st_nxt.out_valid = 1'b1;
      st_nxt.out_data = pop_data;
    end
  end

  assign push_valid = fire && (mode != bsr_pkg::MODE_HOLD);
  assign push_data = '{mode: mode, q: st_nxt.q};

  // ==========================================================================
  // Registers
  // Reset only clears to a constant; defined_o stays low until fully written.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '{clk_prev: 1'b0, q: `BSR_Q_RST, mask: `BSR_MASK_RST, defined: 1'b0,
                ready: 1'b0, overrun: 1'b0, out_valid: 1'b0, out_data: '0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Snapshot FIFO
  bsr_fifo #(
    .WIDTH($bits(bsr_pkg::snap_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data)
  );

  assign q_o = st_r.q;
  assign defined_o = st_r.defined;
  assign edge_ready_o = st_r.ready;
  assign overrun_o = st_r.overrun;
  assign snap_valid_o = st_r.out_valid;
  assign snap_data_o = st_r.out_data;
endmodule : bidir_shift_register8

/* File: inc/bidir_shift_map.svh */
// Constants for the bidirectional eight-bit shift register.
`ifndef BIDIR_SHIFT_MAP_SVH
`define BIDIR_SHIFT_MAP_SVH
// ==========================================================================
// Widths and depths
`define BSR_WIDTH 8
`define BSR_FIFO_DEPTH 32
// ==========================================================================
// Select input codes
`define BSR_SEL_LOAD 2'h0
`define BSR_SEL_LEFT 2'h1
`define BSR_SEL_RIGHT 2'h2
`define BSR_SEL_HOLD 2'h3
// ==========================================================================
// Reset values and the full-write mask
`define BSR_Q_RST 8'h00
`define BSR_MASK_RST 8'h00
`define BSR_MASK_ALL 8'hff
`endif

/* File: inc/bsr_pkg.sv */
// Types shared by the shift register and its snapshot path.
`include "bidir_shift_map.svh"
package bsr_pkg;
  // ==========================================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_LOAD,
    MODE_LEFT,
    MODE_RIGHT,
    MODE_HOLD
  } mode_t;

  // ==========================================================================
  // Snapshot word written after each changing edge
  typedef struct packed {
    mode_t mode;
    logic [`BSR_WIDTH-1:0] q;
  } snap_t;

  // ==========================================================================
  // Complete state of the top module
  typedef struct packed {
    logic clk_prev;
    logic [`BSR_WIDTH-1:0] q;
    logic [`BSR_WIDTH-1:0] mask;
    logic defined;
    logic ready;
    logic overrun;
    logic out_valid;
    snap_t out_data;
  } top_state_t;
endpackage : bsr_pkg

/* File: rtl/bsr_fifo.sv */
// Parameterised synchronous FIFO with valid and ready on both sides.
`include "bidir_shift_map.svh"
module bsr_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = `BSR_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic do_push;
  logic do_pop;

  assign in_ready_o = (st_r.count != CW'(DEPTH));
  assign out_valid_o = (st_r.count != '0);
  assign out_data_o = st_r.mem[st_r.rd_ptr];
  assign do_push = in_valid_i && in_ready_o;
  assign do_pop = out_valid_o && out_ready_i;

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    if (do_push)
    begin
      st_nxt.mem[st_r.wr_ptr] = in_data_i;
      st_nxt.wr_ptr = (st_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + 1'b1;
    end
    if (do_pop)
    begin
      st_nxt.rd_ptr = (st_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : st_r.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      st_nxt.count = st_r.count + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule : bsr_fifo

/* File: dv/bsr_checker.sv */
// Port checker for the eight-bit shift register.
module bsr_checker #(
  parameter int unsigned DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic clk_in_i,
  input wire logic [1:0] sel_i,
  input wire logic ser_lo_i,
  input wire logic ser_hi_i,
  input wire logic [7:0] par_i,
  input wire logic snap_ready_i,
  input wire logic [7:0] q_o,
  input wire logic defined_o,
  input wire logic edge_ready_o,
  input wire logic overrun_o,
  input wire logic snap_valid_o,
  input wire bsr_pkg::snap_t snap_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Edge finder; prev starts low so a pin high at release is an edge.
  logic prev_r;
  wire rise = clk_in_i & ~prev_r;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i) prev_r <= 1'b0;
    else prev_r <= clk_in_i;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_load_par: assert property (rise && sel_i == 2'h0 |=> q_o == $past(par_i))
    else $error("bad load");
  a_shift_left: assert property (rise && sel_i == 2'h1 |=>
    q_o == {$past(q_o[6:0]), $past(ser_lo_i)})
    else $error("bad left");
  a_shift_right: assert property (rise && sel_i == 2'h2 |=>
    q_o == {$past(ser_hi_i), $past(q_o[7:1])})
    else $error("bad right");
  a_hold_sel: assert property (rise && sel_i == 2'h3 |=> $stable(q_o))
    else $error("hold changed q");
  a_edge_only: assert property (!rise |=> $stable(q_o))
    else $error("q moved off edge");
  a_steady_pin: assert property (clk_in_i == prev_r |=> $stable(defined_o))
    else $error("defined moved");
  a_load_defines: assert property (rise && sel_i == 2'h0 |=> defined_o)
    else $error("load left undefined");
  a_snap_mirror: assert property (rise && sel_i == 2'h0 && !snap_valid_o |->
    ##2 snap_valid_o && snap_data_o.q == $past(par_i, 2))
    else $error("bad snapshot");
endmodule : bsr_checker
bind bidir_shift_register8 bsr_checker #(.DEPTH(DEPTH)) i_chk (.*);

/* File: dv/pin_drv.sv */
// Model of the system logic that drives the register's pins.
module pin_drv (
  input wire logic mclk_i,
  output logic clk_o,
  output logic [1:0] sel_o,
  output logic lo_o,
  output logic hi_o,
  output logic [7:0] par_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {clk_o, sel_o, lo_o, hi_o, par_o} = 13'h0;
  // Inputs are inverted after each sample so stale values never pass as held.
  task pulse(input logic [1:0] s, input logic l, input logic h, input logic [7:0] p, input int n);
    @(negedge mclk_i);
    {sel_o, lo_o, hi_o, par_o} = {s, l, h, p};
    clk_o = 1'b1;
    repeat (n + 1)
    begin
      @(negedge mclk_i);
      {sel_o, lo_o, hi_o, par_o} = ~{sel_o, lo_o, hi_o, par_o};
    end
    clk_o = 1'b0;
  endtask : pulse
endmodule : pin_drv

/* File: dv/tb_top.sv */
// Self-checking bench for the eight-bit shift register.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rdy = 1'b0;
  logic drain = 1'b0;
  logic clk_in, lo, hi, dfn, erdy, ovr, sv;
  logic [1:0] sel;
  logic [7:0] par, q;
  bsr_pkg::snap_t sd;
  int miscompares = 0;
  int check_count = 0;
  int ovr_n = 0;
  int taken = 0;
  always #12.5 mclk = ~mclk;
  pin_drv i_drv (.mclk_i(mclk), .clk_o(clk_in), .sel_o(sel), .lo_o(lo), .hi_o(hi), .par_o(par));
  bidir_shift_register8 #(.DEPTH(4)) i_dut (.mclk_i(mclk), .nrst_i(rst_n), .clk_in_i(clk_in),
    .sel_i(sel), .ser_lo_i(lo), .ser_hi_i(hi), .par_i(par), .snap_ready_i(rdy), .q_o(q),
    .defined_o(dfn), .edge_ready_o(erdy), .overrun_o(ovr), .snap_valid_o(sv), .snap_data_o(sd));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  always @(posedge mclk)
  begin
    if (ovr === 1'b1) ovr_n++;
    if (sv === 1'b1 && rdy === 1'b1)
    begin
      if (drain) chk(sd.q, 8'(taken));
      if (drain) chk({6'h00, sd.mode}, 8'h00);
      taken++;
    end
  end
  task give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Load is held high with stirred inputs to show a steady pin changes nothing.
  task t_modes;
    rdy = 1'b1;
    i_drv.pulse(2'h0, 1'b0, 1'b0, 8'ha5, 2);
    chk(q, 8'ha5);
    chk({7'h0, dfn}, 8'h01);
    i_drv.pulse(2'h1, 1'b1, 1'b0, 8'h00, 0);
    chk(q, 8'h4b);
    i_drv.pulse(2'h2, 1'b0, 1'b1, 8'hff, 0);
    chk(q, 8'ha5);
    i_drv.pulse(2'h3, 1'b0, 1'b0, 8'h00, 0);
    chk(q, 8'ha5);
    i_drv.pulse(2'h1, 1'b0, 1'b1, 8'hff, 0);
    chk(q, 8'h4a);
    i_drv.pulse(2'h2, 1'b1, 1'b0, 8'h00, 0);
    chk(q, 8'h25);
  endtask : t_modes
  // Four queued words plus the output word fill the path; the sixth is dropped.
  task t_fill;
    repeat (4) @(negedge mclk);
    rdy = 1'b0;
    ovr_n = 0;
    for (int i = 0; i < 6; i++) i_drv.pulse(2'h0, 1'b0, 1'b0, 8'(i), 0);
    repeat (2) @(negedge mclk);
    chk(8'(ovr_n), 8'h01);
    chk(q, 8'h05);
    chk({7'h0, erdy}, 8'h00);
  endtask : t_fill
  // A second reset in mid-run must clear the word and the defined flag.
  task t_reset;
    @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    chk(q, 8'h00);
    chk({7'h0, dfn}, 8'h00);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk({7'h0, erdy}, 8'h01);
  endtask : t_reset
  task t_drain;
    taken = 0;
    drain = 1'b1;
    rdy = 1'b1;
    for (int n = 0; n < 40 && sv !== 1'b0; n++) @(negedge mclk);
    if (sv !== 1'b0)
    begin
      miscompares++;
      give_verdict();
    end
    chk(8'(taken), 8'h05);
    chk({7'h0, erdy}, 8'h01);
  endtask : t_drain
  initial
  begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    chk({7'h0, dfn}, 8'h00);
    t_modes();
    t_fill();
    t_drain();
    drain = 1'b0;
    t_reset();
    give_verdict();
  end
endmodule : tb_top
